// *** core/dpsr_defines.svh ***
// Register map, field positions, reset values and timing counts of the precharge and self refresh block
`ifndef DPSR_DEFINES_SVH
`define DPSR_DEFINES_SVH
`define DPSR_NBANK 8
`define DPSR_CTRL_OFS 8'h00
`define DPSR_STAT_OFS 8'h04
`define DPSR_VIOL_OFS 8'h08
`define DPSR_CLR_BIT 0
`define DPSR_SREN_BIT 1
`define DPSR_SREN_RST 1'h1
`define DPSR_OPEN_LSB 0
`define DPSR_BUSY_LSB 8
`define DPSR_SR_BIT 16
`define DPSR_DLL_BIT 17
`define DPSR_EXIT_BIT 18
`define DPSR_ODT_LSB 19
`define DPSR_VIOL_LSB 24
`define DPSR_ONE_CLOSE_CYC 4
`define DPSR_ALL_CLOSE_CYC 5
`define DPSR_EXIT_WAIT_CYC 200
`define DPSR_DLL_CYC 200
`define DPSR_CKE_REG 4
`define DPSR_AP_BIT 10
`define DPSR_ODT_HI_BIT 6
`define DPSR_ODT_LO_BIT 2
`define DPSR_EXT_SETUP_BA 2'h1
`define DPSR_OHM_01 8'h4B
`define DPSR_OHM_10 8'h96
`define DPSR_OHM_11 8'h32
`define DPSR_RESP_OK 2'h0
`define DPSR_RESP_ERR 2'h2
`endif

// *** core/dpsr_pkg.sv ***
// Types shared by the precharge and self refresh block
package dpsr_pkg;
    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_OTH} dpsr_cmd_type;
    typedef enum logic [1:0] {ST_NORM, ST_SREF, ST_EXIT} dpsr_sr_type;
    typedef logic [1:0] dpsr_resp_type;
endpackage

// *** core/dpsr_bank_if.sv ***
// Bank command and status bundle between the command decoder and the bank array
`timescale 1ns/1ns
`include "dpsr_defines.svh"
interface dpsr_bank_if;
    logic pre_one;
    logic pre_all;
    logic act;
    logic ap_close;
    logic [2:0] bank;
    logic [`DPSR_NBANK-1:0] open_bits;
    logic [`DPSR_NBANK-1:0] busy_bits;
    modport ctl(output pre_one, pre_all, act, ap_close, bank, input open_bits, busy_bits);
    modport arr(input pre_one, pre_all, act, ap_close, bank, output open_bits, busy_bits);
endinterface

// *** core/dpsr_banks.sv ***
// Per-bank open state and precharge interval down-counters
`timescale 1ns/1ns
`include "dpsr_defines.svh"
module dpsr_banks #(
    parameter int TW = 8,
    parameter int ONE_CLOSE_CYC = `DPSR_ONE_CLOSE_CYC,
    parameter int ALL_CLOSE_CYC = `DPSR_ALL_CLOSE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    dpsr_bank_if.arr bi
);
    import dpsr_pkg::*;
    localparam int NB = `DPSR_NBANK;
    logic [NB-1:0] open_ff;
    logic [TW-1:0] cnt_ff [NB];

    // Counter holds the cycles still to wait; a new precharge always reloads it
    always_ff @(posedge clk) begin
        for (int b = 0; b < NB; b++) begin
            if (!rst_n) begin
                open_ff[b] <= 1'b0;
                cnt_ff[b] <= '0;
            end else if (bi.pre_all) begin
                open_ff[b] <= 1'b0;
                cnt_ff[b] <= TW'(ALL_CLOSE_CYC - 1);
            end else if ((bi.pre_one || bi.ap_close) && bi.bank == 3'(b)) begin
                open_ff[b] <= 1'b0;
                cnt_ff[b] <= TW'(ONE_CLOSE_CYC - 1);
            end else begin
                if (bi.act && bi.bank == 3'(b)) begin
                    open_ff[b] <= 1'b1;
                end
                if (cnt_ff[b] != '0) begin
                    cnt_ff[b] <= cnt_ff[b] - 1'b1;
                end
            end
        end
    end

    always_comb begin
        for (int b = 0; b < NB; b++) begin
            bi.busy_bits[b] = (cnt_ff[b] != '0);
        end
    end

    assign bi.open_bits = open_ff;

    a_pre_one_close: assert property (@(posedge clk) disable iff (!rst_n)
        bi.pre_one && !bi.pre_all |=> !open_ff[$past(bi.bank)] && cnt_ff[$past(bi.bank)] == TW'(ONE_CLOSE_CYC - 1))
        else $error("single bank precharge not timed from this command");

    a_pre_all_close: assert property (@(posedge clk) disable iff (!rst_n)
        bi.pre_all |=> open_ff == '0 && cnt_ff[0] == TW'(ALL_CLOSE_CYC - 1) && cnt_ff[NB-1] == cnt_ff[0])
        else $error("all bank precharge did not close every bank");
endmodule

// *** core/dpsr_top.sv ***
// Precharge and self refresh command engine with AXI4-Lite control and status
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dpsr_defines.svh"
// Functional notes
// - Precharge closes one or all rows; activate waits out the bank interval.
// - A precharged bank is idle; read or write needs an activated row.
// - Precharge to idle or precharging bank is taken; interval restarts.
// - A10 picks one bank or all; bank select ignored for all banks.
// - Self refresh holds contents while the link clock is stopped.
// - Refresh encoding with CKE low enters self refresh.
// - DLL off in self refresh, on at exit; reads wait 200 cycles.
// - In self refresh only CKE is heard.
// - Auto precharge of one bank leaves other banks free.
// - Setup word bits A6,A2: 01 is 75, 10 is 150, 11 is 50 ohm.
module dpsr_top #(
    parameter int CW = 8,
    parameter int AW = 14,
    parameter int ONE_CLOSE_CYC = `DPSR_ONE_CLOSE_CYC,
    parameter int ALL_CLOSE_CYC = `DPSR_ALL_CLOSE_CYC,
    parameter int EXIT_WAIT_CYC = `DPSR_EXIT_WAIT_CYC,
    parameter int DLL_LOCK_CYC = `DPSR_DLL_CYC,
    parameter int CKE_REG_CNT = `DPSR_CKE_REG
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output dpsr_pkg::dpsr_resp_type BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output dpsr_pkg::dpsr_resp_type RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic LINK_CLK,
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic [2:0] BA,
    input wire logic [AW-1:0] ADDR,
    output logic SELF_REFRESH,
    output logic DLL_ON,
    output logic [1:0] ODT_SEL,
    output logic [7:0] ODT_OHMS
);
    import dpsr_pkg::*;

    localparam int EXIT_DLY = EXIT_WAIT_CYC;

    function automatic dpsr_cmd_type dec_cmd(input logic [3:0] c);
        if (c[3]) begin
            return CMD_NOP;
        end
        case (c[2:0])
            3'h7: return CMD_NOP;
            3'h3: return CMD_ACT;
            3'h5: return CMD_RD;
            3'h4: return CMD_WR;
            3'h2: return CMD_PRE;
            3'h1: return CMD_REF;
            3'h0: return CMD_MRS;
            default: return CMD_OTH;
        endcase
    endfunction

    function automatic logic [7:0] ohms(input logic [1:0] s);
        case (s)
            2'h1: return `DPSR_OHM_01;
            2'h2: return `DPSR_OHM_10;
            2'h3: return `DPSR_OHM_11;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic is_reg(input logic [7:0] a);
        return a == `DPSR_CTRL_OFS || a == `DPSR_STAT_OFS || a == `DPSR_VIOL_OFS;
    endfunction

    // Bus side state
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [1:0] wdata_ff;
    logic wstrb_ff;
    dpsr_resp_type bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, rd_word;
    logic do_wr;
    logic sr_en_ff, clr_tgl_ff, req_tgl_ff, ack_s1_ff, ack_s2_ff;
    logic [31:0] stat_ff;

    // Link side state
    logic lrst_s1_ff, lrst_n_ff;
    logic req_s1_ff, req_s2_ff, ack_tgl_ff;
    logic sren_s1_ff, sren_s2_ff, clr_s1_ff, clr_s2_ff, clr_s3_ff;
    logic [31:0] snap_ff, lstat;
    dpsr_cmd_type cmd;
    dpsr_sr_type state_ff, nxt_state;
    logic [2:0] hi_cnt_ff;
    logic [CW-1:0] exit_cnt_ff, dll_cnt_ff;
    logic [7:0] viol_ff, ohm_ff;
    logic [1:0] odt_ff, odt_req;
    logic sr_ff, dll_on_ff;
    logic live, acc_act, acc_rw, acc_emr, sr_go, bad, clr_evt, is_rw;

    dpsr_bank_if bif();

    dpsr_banks #(
        .TW(CW),
        .ONE_CLOSE_CYC(ONE_CLOSE_CYC),
        .ALL_CLOSE_CYC(ALL_CLOSE_CYC)
    ) u_banks (
        .clk(LINK_CLK),
        .rst_n(lrst_n_ff),
        .bi(bif.arr)
    );

    assign AWREADY = awready_ff;
    assign WREADY = wready_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign ARREADY = arready_ff;
    assign RVALID = rvalid_ff;
    assign RRESP = rresp_ff;
    assign RDATA = rdata_ff;
    assign SELF_REFRESH = sr_ff;
    assign DLL_ON = dll_on_ff;
    assign ODT_SEL = odt_ff;
    assign ODT_OHMS = ohm_ff;

    // Address and data are held until both are in, then one write completes
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            awready_ff <= 1'b1;
            awaddr_ff <= 8'h00;
        end else if (AWVALID && awready_ff) begin
            awready_ff <= 1'b0;
            awaddr_ff <= AWADDR;
        end else if (bvalid_ff && BREADY) begin
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wready_ff <= 1'b1;
            wdata_ff <= 2'h0;
            wstrb_ff <= 1'b0;
        end else if (WVALID && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff <= WDATA[1:0];
            wstrb_ff <= WSTRB[0];
        end else if (bvalid_ff && BREADY) begin
            wready_ff <= 1'b1;
        end
    end

    assign do_wr = !awready_ff && !wready_ff && !bvalid_ff;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `DPSR_RESP_OK;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= is_reg(awaddr_ff) ? `DPSR_RESP_OK : `DPSR_RESP_ERR;
        end else if (BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sr_en_ff <= `DPSR_SREN_RST;
            clr_tgl_ff <= 1'b0;
        end else if (do_wr && wstrb_ff && awaddr_ff == `DPSR_CTRL_OFS) begin
            sr_en_ff <= wdata_ff[`DPSR_SREN_BIT];
            clr_tgl_ff <= clr_tgl_ff ^ wdata_ff[`DPSR_CLR_BIT];
        end
    end

    always_comb begin
        rd_word = 32'h0;
        case (ARADDR)
            `DPSR_CTRL_OFS: rd_word[`DPSR_SREN_BIT] = sr_en_ff;
            `DPSR_STAT_OFS: rd_word = {8'h00, stat_ff[23:0]};
            `DPSR_VIOL_OFS: rd_word = {24'h0, stat_ff[`DPSR_VIOL_LSB +: 8]};
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `DPSR_RESP_OK;
        end else if (ARVALID && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= is_reg(ARADDR) ? `DPSR_RESP_OK : `DPSR_RESP_ERR;
        end else if (rvalid_ff && RREADY) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    // Status snapshot handshake: request toggles, copy taken once the ack returns
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            stat_ff <= 32'h0;
        end else begin
            ack_s1_ff <= ack_tgl_ff;
            ack_s2_ff <= ack_s1_ff;
            if (ack_s2_ff == req_tgl_ff) begin
                stat_ff <= snap_ff;
                req_tgl_ff <= ~req_tgl_ff;
            end
        end
    end

    // Link domain reset, released on the link clock
    always_ff @(posedge LINK_CLK) begin
        lrst_s1_ff <= RST_N;
        lrst_n_ff <= lrst_s1_ff;
    end

    always_ff @(posedge LINK_CLK) begin
        if (!lrst_n_ff) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            ack_tgl_ff <= 1'b0;
            snap_ff <= 32'h0;
            sren_s1_ff <= `DPSR_SREN_RST;
            sren_s2_ff <= `DPSR_SREN_RST;
            clr_s1_ff <= 1'b0;
            clr_s2_ff <= 1'b0;
            clr_s3_ff <= 1'b0;
        end else begin
            req_s1_ff <= req_tgl_ff;
            req_s2_ff <= req_s1_ff;
            if (req_s2_ff != ack_tgl_ff) begin
                snap_ff <= lstat;
                ack_tgl_ff <= req_s2_ff;
            end
            sren_s1_ff <= sr_en_ff;
            sren_s2_ff <= sren_s1_ff;
            clr_s1_ff <= clr_tgl_ff;
            clr_s2_ff <= clr_s1_ff;
            clr_s3_ff <= clr_s2_ff;
        end
    end

    assign clr_evt = clr_s2_ff ^ clr_s3_ff;

    always_comb begin
        lstat = 32'h0;
        lstat[`DPSR_OPEN_LSB +: 8] = bif.open_bits;
        lstat[`DPSR_BUSY_LSB +: 8] = bif.busy_bits;
        lstat[`DPSR_SR_BIT] = sr_ff;
        lstat[`DPSR_DLL_BIT] = dll_on_ff;
        lstat[`DPSR_EXIT_BIT] = state_ff == ST_EXIT;
        lstat[`DPSR_ODT_LSB +: 2] = odt_ff;
        lstat[`DPSR_VIOL_LSB +: 8] = viol_ff;
    end

    // Command decode; in self refresh only CKE is looked at, in exit wait any command but NOP counts as a violation
    always_comb begin
        cmd = dec_cmd({CS_N, RAS_N, CAS_N, WE_N});
        is_rw = cmd == CMD_RD || cmd == CMD_WR;
        odt_req = {ADDR[`DPSR_ODT_HI_BIT], ADDR[`DPSR_ODT_LO_BIT]};
        live = state_ff == ST_NORM && CKE;
        acc_act = live && cmd == CMD_ACT && !bif.busy_bits[BA] && !bif.open_bits[BA];
        acc_rw = live && is_rw && bif.open_bits[BA] && !(cmd == CMD_RD && dll_cnt_ff != '0);
        acc_emr = live && cmd == CMD_MRS && BA[1:0] == `DPSR_EXT_SETUP_BA;
        sr_go = state_ff == ST_NORM && !CKE && cmd == CMD_REF && sren_s2_ff;
        bad = (live && ((cmd == CMD_ACT && !acc_act) || (is_rw && !acc_rw)))
            || (state_ff == ST_NORM && !CKE && cmd == CMD_REF && !sren_s2_ff)
            || (state_ff == ST_EXIT && cmd != CMD_NOP);
    end

    assign bif.pre_one = live && cmd == CMD_PRE && !ADDR[`DPSR_AP_BIT];
    assign bif.pre_all = live && cmd == CMD_PRE && ADDR[`DPSR_AP_BIT];
    assign bif.act = acc_act;
    assign bif.ap_close = acc_rw && ADDR[`DPSR_AP_BIT];
    assign bif.bank = BA;

    always_comb begin
        case (state_ff)
            ST_NORM: nxt_state = sr_go ? ST_SREF : ST_NORM;
            ST_SREF: nxt_state = (CKE && hi_cnt_ff == 3'(CKE_REG_CNT - 1)) ? ST_EXIT : ST_SREF;
            ST_EXIT: nxt_state = exit_cnt_ff == '0 ? ST_NORM : ST_EXIT;
            default: nxt_state = ST_NORM;
        endcase
    end

    // Bank state is simply held in self refresh; nothing here needs the link clock to run
    always_ff @(posedge LINK_CLK) begin
        if (!lrst_n_ff) begin
            state_ff <= ST_NORM;
            sr_ff <= 1'b0;
            dll_on_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            sr_ff <= nxt_state == ST_SREF;
            dll_on_ff <= nxt_state != ST_SREF;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (!lrst_n_ff || state_ff != ST_SREF || !CKE) begin
            hi_cnt_ff <= 3'h0;
        end else begin
            hi_cnt_ff <= hi_cnt_ff + 3'h1;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (!lrst_n_ff) begin
            exit_cnt_ff <= '0;
            dll_cnt_ff <= '0;
        end else if (state_ff == ST_SREF && nxt_state == ST_EXIT) begin
            exit_cnt_ff <= CW'(EXIT_WAIT_CYC - 1);
            dll_cnt_ff <= CW'(DLL_LOCK_CYC);
        end else begin
            if (exit_cnt_ff != '0) begin
                exit_cnt_ff <= exit_cnt_ff - 1'b1;
            end
            if (dll_cnt_ff != '0) begin
                dll_cnt_ff <= dll_cnt_ff - 1'b1;
            end
        end
    end

    // Rejected commands are counted; a clear in the same cycle as a new one leaves the count at 1
    always_ff @(posedge LINK_CLK) begin
        if (!lrst_n_ff) begin
            viol_ff <= 8'h00;
        end else if (clr_evt) begin
            viol_ff <= bad ? 8'h01 : 8'h00;
        end else if (bad && viol_ff != 8'hFF) begin
            viol_ff <= viol_ff + 8'h01;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (!lrst_n_ff) begin
            odt_ff <= 2'h0;
            ohm_ff <= 8'h00;
        end else if (acc_emr) begin
            odt_ff <= odt_req;
            ohm_ff <= ohms(odt_req);
        end
    end

    sequence s_in_sr;
        state_ff == ST_SREF ##1 state_ff == ST_SREF;
    endsequence

    sequence s_cke_four;
        (state_ff == ST_SREF && CKE) [*4];
    endsequence

    a_sr_entry: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        sr_go |=> state_ff == ST_SREF && SELF_REFRESH && !DLL_ON)
        else $error("self refresh not entered");

    a_sr_hold: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        s_in_sr |-> $stable(bif.open_bits) && $stable(odt_ff) && !bif.pre_one && !bif.pre_all)
        else $error("state changed during self refresh");

    a_exit_four: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        s_cke_four |=> state_ff == ST_EXIT && DLL_ON && !SELF_REFRESH)
        else $error("exit not taken after four CKE highs");

    a_exit_len: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        $rose(state_ff == ST_EXIT) |-> ##EXIT_DLY state_ff == ST_NORM && $past(state_ff) == ST_EXIT)
        else $error("exit wait length wrong");

    a_exit_quiet: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        state_ff == ST_EXIT && cmd != CMD_NOP |-> !bif.act && !acc_rw && !bif.pre_one && !bif.pre_all)
        else $error("command taken during exit wait");

    a_read_dll: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        acc_rw && cmd == CMD_RD |-> dll_cnt_ff == '0 && DLL_ON)
        else $error("read taken before DLL relock");

    a_act_guard: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        bif.act |-> !bif.busy_bits[BA] ##1 bif.open_bits[$past(BA)])
        else $error("activate during precharge interval");

    a_rw_open: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        acc_rw |-> bif.open_bits[BA] && state_ff == ST_NORM)
        else $error("read or write to idle bank");

    a_ext_setup: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_ff)
        acc_emr |=> ODT_SEL == $past(odt_req) && ODT_OHMS == ohms(ODT_SEL))
        else $error("termination select not applied");
endmodule

// *** test/dpsr_ctl_model.sv ***
// Memory controller model that drives the command pins on its own link clock
`timescale 1ns/1ns
module dpsr_ctl_model (
    output logic lclk,
    output logic cke,
    output logic [3:0] cmd_n,
    output logic [2:0] ba,
    output logic [13:0] addr
);
    logic run = 1'b1;
    initial begin
        lclk = 1'b0;
        cke = 1'b1;
        cmd_n = 4'hF;
        ba = 3'h0;
        addr = 14'h0;
    end
    always #16 if (run) lclk = ~lclk;
    // Pins change mid-cycle and are taken at the next rising edge
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input logic k);
        @(negedge lclk);
        cmd_n <= c;
        ba <= b;
        addr <= a;
        cke <= k;
        @(posedge lclk);
    endtask
    task automatic nops(input int n, input logic k);
        repeat (n) cmd(4'h7, ~ba, ~addr, k);
    endtask
    task automatic halt();
        repeat (2) @(posedge lclk);
        run = 1'b0;
        cmd_n <= ~cmd_n;
        addr <= ~addr;
    endtask
    task automatic resume();
        run = 1'b1;
        repeat (2) @(posedge lclk);
    endtask
endmodule

// *** test/tb_ddr2_precharge_self_refresh.sv ***
// Self-checking bench for the precharge and self refresh block
`timescale 1ns/1ns
`include "dpsr_defines.svh"
module tb_ddr2_precharge_self_refresh;
    import dpsr_pkg::*;
    localparam int ONE = `DPSR_ONE_CLOSE_CYC;
    localparam int ALL = `DPSR_ALL_CLOSE_CYC;
    localparam int EXW = 8;
    localparam logic [3:0] ACT = 4'h3;
    localparam logic [3:0] RD = 4'h5;
    localparam logic [3:0] WR = 4'h4;
    localparam logic [3:0] PRE = 4'h2;
    localparam logic [3:0] REF = 4'h1;
    localparam logic [7:0] CTRL = `DPSR_CTRL_OFS;
    localparam logic [7:0] STAT = `DPSR_STAT_OFS;
    localparam logic [7:0] VIOL = `DPSR_VIOL_OFS;
    localparam dpsr_resp_type OK = `DPSR_RESP_OK;
    localparam dpsr_resp_type ERR = `DPSR_RESP_ERR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sref, dll, lclk, cke;
    logic [31:0] rdata;
    dpsr_resp_type bresp, rresp;
    logic [1:0] odt_sel;
    logic [7:0] odt_ohms;
    logic [3:0] cmd_n;
    logic [2:0] ba;
    logic [13:0] addr;
    logic [7:0] ohm [4] = '{8'h00, `DPSR_OHM_01, `DPSR_OHM_10, `DPSR_OHM_11};
    int failures = 0;
    int tests_run = 0;

    always #10 clk = ~clk;

    dpsr_ctl_model i_ctl (.lclk(lclk), .cke(cke), .cmd_n(cmd_n), .ba(ba), .addr(addr));

    dpsr_top #(.EXIT_WAIT_CYC(EXW), .DLL_LOCK_CYC(EXW)) i_dut (
        .CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .LINK_CLK(lclk),
        .CKE(cke), .CS_N(cmd_n[3]), .RAS_N(cmd_n[2]), .CAS_N(cmd_n[1]), .WE_N(cmd_n[0]),
        .BA(ba), .ADDR(addr), .SELF_REFRESH(sref), .DLL_ON(dll), .ODT_SEL(odt_sel), .ODT_OHMS(odt_ohms)
    );

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] v, input dpsr_resp_type er);
        logic aw, w;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(posedge clk);
            if (awready === 1'b1) aw = 1'b0;
            if (wready === 1'b1) w = 1'b0;
            awvalid <= aw;
            wvalid <= w;
        end
        bready <= 1'b1;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        // Let the control change reach the link side
        repeat (25) @(posedge clk);
    endtask

    // Waits out the status snapshot lag before reading
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input dpsr_resp_type er);
        repeat (25) @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata & m, e);
        chk(32'(rresp), 32'(er));
    endtask

    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (40) @(posedge clk);
        rd_chk(CTRL, 32'hFFFFFFFF, 32'h2, OK);
        rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0, ERR);
        wr_chk(8'h10, 32'h0, ERR);
        wr_chk(STAT, 32'hFFFFFFFF, OK);
        i_ctl.nops(3, 1'b1);
        i_ctl.cmd(ACT, 3'h2, 14'h0, 1'b1);
        i_ctl.cmd(ACT, 3'h5, 14'h0, 1'b1);
        i_ctl.cmd(PRE, 3'h2, 14'h0, 1'b1);
        i_ctl.nops(ONE - 2, 1'b1);
        i_ctl.cmd(ACT, 3'h2, 14'h0, 1'b1);
        i_ctl.cmd(ACT, 3'h2, 14'h0, 1'b1);
        i_ctl.cmd(PRE, 3'h2, 14'h0, 1'b1);
        i_ctl.nops(1, 1'b1);
        i_ctl.cmd(PRE, 3'h2, 14'h0, 1'b1);
        i_ctl.nops(ONE - 2, 1'b1);
        i_ctl.cmd(ACT, 3'h2, 14'h0, 1'b1);
        i_ctl.cmd(ACT, 3'h2, 14'h0, 1'b1);
        i_ctl.nops(1, 1'b1);
        rd_chk(STAT, 32'hFF, 32'h24, OK);
        rd_chk(VIOL, 32'hFF, 32'h2, OK);
        i_ctl.cmd(PRE, 3'h5, 14'h0, 1'b1);
        i_ctl.cmd(RD, 3'h5, 14'h0, 1'b1);
        i_ctl.cmd(WR, 3'h5, 14'h0, 1'b1);
        i_ctl.cmd(WR, 3'h2, 14'h400, 1'b1);
        i_ctl.cmd(ACT, 3'h2, 14'h0, 1'b1);
        i_ctl.cmd(ACT, 3'h5, 14'h0, 1'b1);
        i_ctl.nops(1, 1'b1);
        rd_chk(STAT, 32'hFF, 32'h20, OK);
        i_ctl.cmd(ACT, 3'h1, 14'h0, 1'b1);
        i_ctl.cmd(ACT, 3'h3, 14'h0, 1'b1);
        i_ctl.cmd(PRE, 3'h6, 14'h400, 1'b1);
        i_ctl.nops(ALL - 2, 1'b1);
        i_ctl.cmd(ACT, 3'h1, 14'h0, 1'b1);
        i_ctl.cmd(ACT, 3'h1, 14'h0, 1'b1);
        i_ctl.nops(1, 1'b1);
        rd_chk(STAT, 32'hFF, 32'h02, OK);
        rd_chk(VIOL, 32'hFF, 32'h6, OK);
        for (int i = 0; i < 4; i++) begin
            i_ctl.cmd(4'h0, 3'h1, {7'h0, i[1], 3'h0, i[0], 2'h0}, 1'b1);
            i_ctl.nops(1, 1'b1);
            chk(32'(odt_sel), 32'(i[1:0]));
            chk(32'(odt_ohms), 32'(ohm[i]));
        end
        i_ctl.cmd(REF, 3'h0, 14'h0, 1'b0);
        i_ctl.nops(1, 1'b0);
        chk(32'(sref), 32'h1);
        chk(32'(dll), 32'h0);
        i_ctl.halt();
        repeat (20) @(posedge clk);
        i_ctl.resume();
        i_ctl.cmd(ACT, 3'h4, 14'h0, 1'b0);
        i_ctl.cmd(PRE, 3'h1, 14'h400, 1'b0);
        i_ctl.nops(1, 1'b0);
        rd_chk(STAT, 32'h30002, 32'h10002, OK);
        rd_chk(VIOL, 32'hFF, 32'h6, OK);
        i_ctl.nops(3, 1'b1);
        chk(32'(sref), 32'h1);
        i_ctl.nops(2, 1'b1);
        chk(32'(sref), 32'h0);
        chk(32'(dll), 32'h1);
        i_ctl.cmd(RD, 3'h1, 14'h0, 1'b1);
        i_ctl.nops(EXW, 1'b1);
        i_ctl.cmd(RD, 3'h1, 14'h0, 1'b1);
        i_ctl.nops(1, 1'b1);
        rd_chk(VIOL, 32'hFF, 32'h7, OK);
        wr_chk(CTRL, 32'h1, OK);
        i_ctl.cmd(REF, 3'h0, 14'h0, 1'b0);
        i_ctl.nops(1, 1'b1);
        chk(32'(sref), 32'h0);
        rd_chk(VIOL, 32'hFF, 32'h1, OK);
        wr_chk(CTRL, 32'h3, OK);
        rd_chk(VIOL, 32'hFF, 32'h0, OK);
        rd_chk(CTRL, 32'hFFFFFFFF, 32'h2, OK);
        tally_and_finish();
    end
endmodule
